// File: hw/bmc_col_gen.sv
// Collision test generator: raises COL while TX_EN is held in test mode.
`timescale 1ns/1ps
`include "bmc_regs.svh"
module bmc_col_gen (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Link to control block
  bmc_if.col_gen    lnk
);
  import bmc_pkg::*;

  col_gen_state_t st;
  col_gen_state_t next_st;

  assign lnk.col = st.col;

  // COL rises a fixed number of bit times after TX_EN, well inside 512.
  always_comb begin
    next_st = st;
    case (st.state)
      COL_IDLE: begin
        next_st.col  = 1'b0;
        next_st.bits = 10'h000;
        if (lnk.tx_en && lnk.col_test) begin
          next_st.state = COL_WAIT;
        end
      end
      COL_WAIT: begin
        if (!lnk.tx_en || !lnk.col_test) begin
          next_st.state = COL_IDLE;
        end else if (lnk.bit_tick) begin
          next_st.bits = st.bits + 10'h001;
          if (st.bits == 10'(`BMC_COL_ASSERT_BITS - 1)) begin
            next_st.state = COL_ON;
            next_st.col   = 1'b1;
          end
        end
      end
      COL_ON: begin
        if (!lnk.tx_en || !lnk.col_test) begin
          next_st.state = COL_IDLE;
          next_st.col   = 1'b0;
        end
      end
      default: begin
        next_st.state = COL_IDLE;
        next_st.col   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{state: COL_IDLE, bits: 10'h000, col: 1'b0};
    end else begin
      st <= next_st;
    end
  end
endmodule

// File: hw/bmc_dead_timer.sv
// Receive dead-time timer started when loopback is switched on.
`timescale 1ns/1ps
`include "bmc_regs.svh"
module bmc_dead_timer #(
  parameter int DEAD_CYCLES = `BMC_DEAD_CYCLES
) (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // Link to control block
  bmc_if.dead       lnk
);
  import bmc_pkg::*;

  dead_state_t st;
  dead_state_t next_st;

  assign lnk.dead_busy = st.busy;

  always_comb begin
    next_st = st;
    if (lnk.dead_start) begin
      next_st.busy  = 1'b1;
      next_st.count = 16'(DEAD_CYCLES - 1);
    end else if (st.busy) begin
      if (st.count == 16'h0000) begin
        next_st.busy = 1'b0;
      end else begin
        next_st.count = st.count - 16'h0001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{busy: 1'b0, count: 16'h0000};
    end else begin
      st <= next_st;
    end
  end
endmodule

// File: hw/bmc_if.sv
// Signals between the control block and its two helper modules.
`timescale 1ns/1ps
interface bmc_if;
  logic bit_tick;
  logic tx_en;
  logic col_test;
  logic col;
  logic dead_start;
  logic dead_busy;

  modport ctrl    (output bit_tick, tx_en, col_test, dead_start,
                   input  col, dead_busy);
  modport col_gen (input  bit_tick, tx_en, col_test,
                   output col);
  modport dead    (input  dead_start,
                   output dead_busy);
endinterface

// File: hw/bmc_pkg.sv
// Types shared by the basic mode control block and its helpers.
package bmc_pkg;

  typedef enum logic [2:0] {
    COL_IDLE = 3'b001,
    COL_WAIT = 3'b010,
    COL_ON   = 3'b100
  } col_state_t;

  typedef struct packed {
    col_state_t state;
    logic [9:0] bits;
    logic       col;
  } col_gen_state_t;

  typedef struct packed {
    logic        busy;
    logic [15:0] count;
  } dead_state_t;

  typedef struct packed {
    logic        loopback;
    logic        speed;
    logic        an_enable;
    logic        power_down;
    logic        isolate;
    logic        an_restart;
    logic        duplex;
    logic        col_test;
    logic [1:0]  strap_wait;
    logic        strap_done;
    logic [2:0]  strap_meta;
    logic [2:0]  strap_sync;
    logic        pd_meta;
    logic        pd_sync_n;
    logic [3:0]  bit_div;
    logic        bit_tick;
    logic        dead_start;
    logic [15:0] rdata;
    logic        o_speed;
    logic        o_duplex;
    logic        o_power_down;
    logic [3:0]  o_rxd;
    logic        o_rx_dv;
    logic        o_col;
    logic        o_mii_enable;
  } ctrl_state_t;

endpackage

// File: hw/bmc_regs.svh
// Register offsets, bit positions, reset values and timing counts.
`ifndef BMC_REGS_SVH
`define BMC_REGS_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define BMC_ADDR_W          5
`define BMC_ADDR_CONTROL    5'h00
`define BMC_DATA_W          16
`define BMC_RESET_VALUE     16'h0000

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BMC_BIT_SOFT_RESET  15
`define BMC_BIT_LOOPBACK    14
`define BMC_BIT_SPEED       13
`define BMC_BIT_AN_ENABLE   12
`define BMC_BIT_POWER_DOWN  11
`define BMC_BIT_ISOLATE     10
`define BMC_BIT_AN_RESTART  9
`define BMC_BIT_DUPLEX      8
`define BMC_BIT_COL_TEST    7
`define BMC_RSVD_W          7
`define BMC_RSVD_VALUE      7'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BMC_CLK_PERIOD_NS   10
`define BMC_CLK_MHZ         100
`define BMC_DEAD_TIME_US    500
`define BMC_DEAD_CYCLES     (`BMC_DEAD_TIME_US * `BMC_CLK_MHZ)
`define BMC_BIT_NS_10M      100
`define BMC_BIT_CYCLES_10M  (`BMC_BIT_NS_10M / `BMC_CLK_PERIOD_NS)
`define BMC_COL_LIMIT_BITS  512
`define BMC_COL_ASSERT_BITS 16
`define BMC_STRAP_WAIT      2'h2

`endif

// File: hw/phy_basic_mode_control.sv
// Basic mode control register of a 10/100 transceiver and its effects.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "bmc_regs.svh"
module phy_basic_mode_control #(
  parameter int DEAD_CYCLES = `BMC_DEAD_CYCLES
) (
  // Clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST_N,

  // Register port
  input  wire logic [4:0]  I_ADDR,
  input  wire logic [15:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [15:0] O_RDATA,

  // Strap and power-down pins
  input  wire logic        I_STRAP_SPEED,
  input  wire logic        I_STRAP_AN_ENABLE,
  input  wire logic        I_STRAP_DUPLEX,
  input  wire logic        I_EXTERNAL_POWER_DOWN_INPUT_N,

  // Auto-negotiation engine
  input  wire logic        I_AN_STARTED,
  input  wire logic        I_AN_SPEED_100,
  input  wire logic        I_AN_FULL_DUPLEX,
  output logic             O_AN_ENABLE,
  output logic             O_AN_RESTART,

  // Operating mode
  output logic             O_SPEED_100,
  output logic             O_FULL_DUPLEX,
  output logic             O_POWER_DOWN,
  output logic             O_ISOLATE,
  output logic             O_LOOPBACK,

  // MII from the MAC and line side
  input  wire logic        I_TX_EN,
  input  wire logic [3:0]  I_TXD,
  input  wire logic [3:0]  I_LINE_RXD,
  input  wire logic        I_LINE_RX_DV,
  input  wire logic        I_LINE_COL,
  output logic      [3:0]  O_RXD,
  output logic             O_RX_DV,
  output logic             O_COL,
  output logic             O_MII_ENABLE
);
  import bmc_pkg::*;

  // --------------------------------------------------------------------
  // State and helpers
  // --------------------------------------------------------------------
  ctrl_state_t st;
  ctrl_state_t next_st;
  bmc_if       lnk ();

  logic        wr_hit;
  logic        rd_hit;
  logic        pin_down;
  logic        rx_blank;

  // Only the control word is mapped; other addresses are ignored.
  // The pin is read only after its second synchroniser stage.
  assign wr_hit   = I_WR && (I_ADDR == `BMC_ADDR_CONTROL);
  assign rd_hit   = I_RD && (I_ADDR == `BMC_ADDR_CONTROL);
  assign pin_down = !st.pd_sync_n;

  // Collision test is held off while the MII is cut off.
  // The generator sees transmit enable on the same clock.
  assign lnk.bit_tick   = st.bit_tick;
  assign lnk.tx_en      = I_TX_EN;
  assign lnk.col_test   = st.col_test && !st.power_down && !st.isolate;
  assign lnk.dead_start = st.dead_start;

  bmc_col_gen u_col_gen (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .lnk     (lnk.col_gen)
  );

  bmc_dead_timer #(
    .DEAD_CYCLES (DEAD_CYCLES)
  ) u_dead_timer (
    .i_clk   (I_CLOCK),
    .i_rst_n (I_RST_N),
    .lnk     (lnk.dead)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    next_st            = st;
    next_st.dead_start = 1'b0;

    // ------------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------------
    // Pins cross into the clock domain through two flip-flops.
    next_st.strap_meta = {I_STRAP_SPEED, I_STRAP_AN_ENABLE, I_STRAP_DUPLEX};
    next_st.strap_sync = st.strap_meta;
    next_st.pd_meta    = I_EXTERNAL_POWER_DOWN_INPUT_N;
    next_st.pd_sync_n  = st.pd_meta;

    // ------------------------------------------------------------------
    // Bit-time divider
    // ------------------------------------------------------------------
    // Bit-time enable: every cycle at 100 Mb/s, every tenth at 10 Mb/s.
    if (st.o_speed || st.bit_div == 4'(`BMC_BIT_CYCLES_10M - 1)) begin
      next_st.bit_div  = 4'h0;
      next_st.bit_tick = 1'b1;
    end else begin
      next_st.bit_div  = st.bit_div + 4'h1;
      next_st.bit_tick = 1'b0;
    end

    // ------------------------------------------------------------------
    // Register write
    // ------------------------------------------------------------------
    // Reserved bits 6..0 and bit 15 are dropped.
    // A restart is only accepted together with negotiation enabled.
    if (wr_hit) begin
      next_st.loopback   = I_WDATA[`BMC_BIT_LOOPBACK];
      next_st.speed      = I_WDATA[`BMC_BIT_SPEED];
      next_st.an_enable  = I_WDATA[`BMC_BIT_AN_ENABLE];
      next_st.power_down = I_WDATA[`BMC_BIT_POWER_DOWN];
      next_st.isolate    = I_WDATA[`BMC_BIT_ISOLATE];
      next_st.duplex     = I_WDATA[`BMC_BIT_DUPLEX];
      next_st.col_test   = I_WDATA[`BMC_BIT_COL_TEST];
      if (!I_WDATA[`BMC_BIT_AN_ENABLE]) begin
        next_st.an_restart = 1'b0;
      end else if (I_WDATA[`BMC_BIT_AN_RESTART]) begin
        next_st.an_restart = 1'b1;
      end
      // A zero written to the restart bit changes nothing.
      if (I_WDATA[`BMC_BIT_LOOPBACK] && !st.loopback) begin
        next_st.dead_start = 1'b1;
      end
    end

    // ------------------------------------------------------------------
    // Restart handshake
    // ------------------------------------------------------------------
    // Restart self-clears once the engine reports it has started.
    // A new request in the same cycle wins over the start report.
    if (I_AN_STARTED && st.an_restart &&
        !(wr_hit && I_WDATA[`BMC_BIT_AN_RESTART])) begin
      next_st.an_restart = 1'b0;
    end

    // ------------------------------------------------------------------
    // External power down
    // ------------------------------------------------------------------
    // The external pin sets the bit and wins over a write of zero.
    if (pin_down) begin
      next_st.power_down = 1'b1;
    end

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    // Strap values are taken once the synchronisers have settled.
    if (!st.strap_done) begin
      if (st.strap_wait == `BMC_STRAP_WAIT) begin
        next_st.strap_done = 1'b1;
        next_st.speed      = st.strap_sync[2];
        next_st.an_enable  = st.strap_sync[1];
        next_st.duplex     = st.strap_sync[0];
      end else begin
        next_st.strap_wait = st.strap_wait + 2'h1;
      end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Read data stands for one cycle only.
    if (rd_hit) begin
      next_st.rdata = {1'b0,
                       st.loopback,
                       st.speed,
                       st.an_enable,
                       st.power_down,
                       st.isolate,
                       st.an_restart,
                       st.duplex,
                       st.col_test,
                       `BMC_RSVD_VALUE};
    end else begin
      next_st.rdata = 16'h0000;
    end

    // ------------------------------------------------------------------
    // Operating mode
    // ------------------------------------------------------------------
    // Operating mode from negotiation result or from the register.
    if (next_st.an_enable) begin
      next_st.o_speed  = I_AN_SPEED_100;
      next_st.o_duplex = I_AN_FULL_DUPLEX;
    end else begin
      next_st.o_speed  = next_st.speed;
      next_st.o_duplex = next_st.duplex;
    end

    next_st.o_power_down = next_st.power_down || pin_down;
    next_st.o_mii_enable = !next_st.isolate && !next_st.o_power_down;

    // ------------------------------------------------------------------
    // Receive path
    // ------------------------------------------------------------------
    // Loopback replaces line data, blanked when cut off.
    // Valid is also held off in the two cycles before the timer runs.
    rx_blank = lnk.dead_busy || st.dead_start || next_st.dead_start;
    if (!next_st.o_mii_enable) begin
      next_st.o_rxd   = 4'h0;
      next_st.o_rx_dv = 1'b0;
      next_st.o_col   = 1'b0;
    end else begin
      if (st.loopback) begin
        next_st.o_rxd   = I_TXD;
        next_st.o_rx_dv = I_TX_EN && !rx_blank;
      end else begin
        next_st.o_rxd   = I_LINE_RXD;
        next_st.o_rx_dv = I_LINE_RX_DV && !rx_blank;
      end
      if (st.col_test) begin
        next_st.o_col = lnk.col;
      end else begin
        next_st.o_col = I_LINE_COL && !st.loopback;
      end
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      // The power-down pin synchronisers start at its idle level; strap ones at zero.
      st <= '0;
      st.pd_meta      <= 1'b1;
      st.pd_sync_n    <= 1'b1;
      st.o_mii_enable <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign O_RDATA       = st.rdata;
  assign O_AN_ENABLE   = st.an_enable;
  assign O_AN_RESTART  = st.an_restart;
  assign O_SPEED_100   = st.o_speed;
  assign O_FULL_DUPLEX = st.o_duplex;
  assign O_POWER_DOWN  = st.o_power_down;
  assign O_ISOLATE     = st.isolate;
  assign O_LOOPBACK    = st.loopback;
  assign O_RXD         = st.o_rxd;
  assign O_RX_DV       = st.o_rx_dv;
  assign O_COL         = st.o_col;
  assign O_MII_ENABLE  = st.o_mii_enable;
endmodule

// File: sim/bmc_an_engine.sv
// Negotiation engine stand-in that takes a pending restart after a delay.
`timescale 1ns/1ps
module bmc_an_engine (
  // Clock and reset
  input  logic i_clk,
  input  logic i_rst_n,
  // Pending restart from the block, stall from the bench
  input  logic i_restart,
  input  logic i_stall,
  // Start pulse back to the block
  output logic o_started
);
  logic [2:0] wait_cnt;

  // A stalled engine never starts, so a restart stays pending.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wait_cnt  <= 3'h0;
      o_started <= 1'h0;
    end else begin
      o_started <= 1'h0;
      if (!i_restart || i_stall) begin
        wait_cnt <= 3'h0;
      end else if (wait_cnt == 3'h4) begin
        o_started <= 1'h1;
        wait_cnt  <= 3'h0;
      end else begin
        wait_cnt <= wait_cnt + 3'h1;
      end
    end
  end
endmodule

// File: sim/phy_basic_mode_control_properties.sv
// Checker of the basic mode control block, bound to its top module.
`timescale 1ns/1ps
module bmc_checker #(
  parameter int DEAD_CYCLES = 20
) (
  // Clock, reset and register port
  input logic        I_CLOCK,
  input logic        I_RST_N,
  input logic [4:0]  I_ADDR,
  input logic [15:0] I_WDATA,
  input logic        I_WR,
  input logic        I_RD,
  input logic [15:0] O_RDATA,
  // Pins and mode outputs
  input logic        I_EXTERNAL_POWER_DOWN_INPUT_N,
  input logic        I_AN_STARTED,
  input logic        O_AN_ENABLE,
  input logic        O_AN_RESTART,
  input logic        O_SPEED_100,
  input logic        O_FULL_DUPLEX,
  input logic        O_POWER_DOWN,
  input logic        O_ISOLATE,
  input logic        O_LOOPBACK,
  // MII
  input logic        I_TX_EN,
  input logic        O_RX_DV,
  input logic        O_COL,
  input logic        O_MII_ENABLE
);
  logic wr0;
  logic ct;
  logic off;

  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  assign wr0 = I_WR && I_ADDR == 5'h00;
  assign off = O_ISOLATE || O_POWER_DOWN;

  // Tracks the collision-test bit, which has no port of its own.
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ct <= 1'h0;
    end else if (wr0) begin
      ct <= I_WDATA[7];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_reserved_zero: assert property (
    O_RDATA[15] == 1'h0 && O_RDATA[6:0] == 7'h00)
    else $error("reserved read bits not zero");
  a_idle_read_zero: assert property (
    !(I_RD && I_ADDR == 5'h00) |=> O_RDATA == 16'h0000)
    else $error("read data not zero outside a read");
  a_read_fields: assert property (
    $past(I_RD) && $past(I_ADDR) == 5'h00 |->
    O_RDATA[14:9] == {$past(O_LOOPBACK), O_RDATA[13], $past(O_AN_ENABLE),
                      O_RDATA[11], $past(O_ISOLATE), $past(O_AN_RESTART)})
    else $error("read data does not match control state");
  a_forced_mode: assert property (
    wr0 && !I_WDATA[12] |=> O_SPEED_100 == $past(I_WDATA[13]) &&
    O_FULL_DUPLEX == $past(I_WDATA[8]))
    else $error("forced speed or duplex wrong");
  a_restart_set: assert property (
    wr0 && I_WDATA[12] && I_WDATA[9] |=> O_AN_RESTART)
    else $error("restart not pending after write");
  a_restart_ignored: assert property (
    wr0 && !I_WDATA[12] |=> !O_AN_RESTART)
    else $error("restart pending with negotiation off");
  a_restart_hold: assert property (
    O_AN_RESTART && !I_AN_STARTED && !(wr0 && !I_WDATA[12]) |=> O_AN_RESTART)
    else $error("restart cleared before start");
  a_pin_power: assert property (
    (!I_EXTERNAL_POWER_DOWN_INPUT_N)[*5] |-> O_POWER_DOWN)
    else $error("pin power down not effective");
  a_isolate_quiet: assert property (
    off && $past(off) |-> !O_MII_ENABLE && !O_RX_DV && !O_COL)
    else $error("MII active while isolated or down");
  a_dead_time: assert property (
    $rose(O_LOOPBACK) |-> (!O_RX_DV)[*8])
    else $error("receive valid inside dead time");
  a_col_rise: assert property (
    $rose(I_TX_EN) && ct && O_SPEED_100 && !off && !O_LOOPBACK |->
    ##[1:514] O_COL)
    else $error("collision test too slow");
  a_col_fall: assert property (
    $fell(I_TX_EN) && ct && O_SPEED_100 |-> ##[0:6] !O_COL)
    else $error("collision not dropped in time");

  c_col: cover property (ct && O_COL);
  c_restart: cover property (O_AN_RESTART ##1 !O_AN_RESTART);
  c_loop: cover property ($rose(O_LOOPBACK));
endmodule

bind phy_basic_mode_control bmc_checker #(.DEAD_CYCLES(DEAD_CYCLES)) chk (
  .I_CLOCK(I_CLOCK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA),
  .I_EXTERNAL_POWER_DOWN_INPUT_N(I_EXTERNAL_POWER_DOWN_INPUT_N),
  .I_AN_STARTED(I_AN_STARTED), .O_AN_ENABLE(O_AN_ENABLE),
  .O_AN_RESTART(O_AN_RESTART), .O_SPEED_100(O_SPEED_100),
  .O_FULL_DUPLEX(O_FULL_DUPLEX), .O_POWER_DOWN(O_POWER_DOWN),
  .O_ISOLATE(O_ISOLATE), .O_LOOPBACK(O_LOOPBACK), .I_TX_EN(I_TX_EN),
  .O_RX_DV(O_RX_DV), .O_COL(O_COL), .O_MII_ENABLE(O_MII_ENABLE));

// File: sim/phy_basic_mode_control_tb_top.sv
// Self-checking testbench of the basic mode control block.
`timescale 1ns/1ps
module phy_basic_mode_control_tb_top;
  import bmc_pkg::*;
  logic        clk;
  logic        rst_n;
  logic [4:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [15:0] rdata;
  logic [2:0]  strap;
  logic        pd_n;
  logic        started;
  logic [1:0]  an_res;
  logic        stall;
  logic        tx_en;
  logic [3:0]  txd;
  logic [3:0]  line_rxd;
  logic        line_dv;
  logic        line_col;
  logic        an_en;
  logic        an_rst;
  logic        spd;
  logic        dup;
  logic        pd;
  logic        iso;
  logic        lb;
  logic [3:0]  rxd;
  logic        rx_dv;
  logic        col;
  logic        mii_en;
  int          miscompares;
  int          total_checks;
  int          cycles;

  phy_basic_mode_control #(.DEAD_CYCLES(20)) dut (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_ADDR(addr), .I_WDATA(wdata),
    .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_STRAP_SPEED(strap[2]),
    .I_STRAP_AN_ENABLE(strap[1]), .I_STRAP_DUPLEX(strap[0]),
    .I_EXTERNAL_POWER_DOWN_INPUT_N(pd_n), .I_AN_STARTED(started),
    .I_AN_SPEED_100(an_res[1]), .I_AN_FULL_DUPLEX(an_res[0]),
    .O_AN_ENABLE(an_en), .O_AN_RESTART(an_rst), .O_SPEED_100(spd),
    .O_FULL_DUPLEX(dup), .O_POWER_DOWN(pd), .O_ISOLATE(iso),
    .O_LOOPBACK(lb), .I_TX_EN(tx_en), .I_TXD(txd), .I_LINE_RXD(line_rxd),
    .I_LINE_RX_DV(line_dv), .I_LINE_COL(line_col), .O_RXD(rxd),
    .O_RX_DV(rx_dv), .O_COL(col), .O_MII_ENABLE(mii_en));

  bmc_an_engine engine (.i_clk(clk), .i_rst_n(rst_n), .i_restart(an_rst),
    .i_stall(stall), .o_started(started));

  // ----------------------------------------------------------------
  // Bus and check helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
    #1;
  endtask

  task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk("read data", rdata, exp);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_reg(5'h00, 16'h3000);
    wr_reg(5'h00, 16'h807f);
    rd_reg(5'h00, 16'h0000);
    wr_reg(5'h00, 16'h2100);
    chk("forced mode", 16'({spd, dup}), 16'h3);
    wr_reg(5'h03, 16'h0000);
    rd_reg(5'h00, 16'h2100);
    rd_reg(5'h01, 16'h0000);
    @(posedge clk);
    an_res <= 2'h1;
    wr_reg(5'h00, 16'h3000);
    tick(2);
    chk("negotiated mode", 16'({spd, dup}), 16'h1);
  endtask

  task automatic t_restart();
    stall <= 1'h1;
    wr_reg(5'h00, 16'h1200);
    chk("restart pending", 16'(an_rst), 16'h1);
    rd_reg(5'h00, 16'h1200);
    wr_reg(5'h00, 16'h1000);
    chk("restart kept", 16'(an_rst), 16'h1);
    stall <= 1'h0;
    for (int i = 0; i < 20 && an_rst; i++) tick(1);
    chk("restart cleared", 16'(an_rst), 16'h0);
    wr_reg(5'h00, 16'h0200);
    rd_reg(5'h00, 16'h0000);
  endtask

  task automatic t_power();
    wr_reg(5'h00, 16'h0800);
    tick(1);
    chk("power down", 16'({pd, mii_en}), 16'h2);
    rd_reg(5'h00, 16'h0800);
    wr_reg(5'h00, 16'h0000);
    @(posedge clk);
    pd_n <= 1'h0;
    tick(5);
    chk("pin power down", 16'(pd), 16'h1);
    rd_reg(5'h00, 16'h0800);
    @(posedge clk);
    pd_n <= 1'h1;
    tick(4);
    wr_reg(5'h00, 16'h0000);
    tick(1);
    chk("power up", 16'(pd), 16'h0);
  endtask

  task automatic t_isolate();
    @(posedge clk);
    line_dv <= 1'h1;
    line_rxd <= 4'ha;
    wr_reg(5'h00, 16'h0400);
    tick(2);
    chk("isolated", 16'({iso, mii_en, rx_dv}), 16'h4);
    rd_reg(5'h00, 16'h0400);
    wr_reg(5'h00, 16'h0000);
    tick(2);
    chk("connected", 16'({mii_en, rx_dv, rxd}), 16'h3a);
  endtask

  task automatic t_loop();
    @(posedge clk);
    tx_en <= 1'h1;
    txd <= 4'h5;
    wr_reg(5'h00, 16'h4000);
    tick(3);
    chk("dead time", 16'(rx_dv), 16'h0);
    tick(25);
    chk("looped data", 16'({rx_dv, rxd}), 16'h15);
    @(posedge clk);
    tx_en <= 1'h0;
    line_dv <= 1'h0;
    wr_reg(5'h00, 16'h0000);
  endtask

  task automatic t_col();
    int n;
    wr_reg(5'h00, 16'h2080);
    @(posedge clk);
    tx_en <= 1'h1;
    n = 0;
    while (!col && n < 600) begin
      tick(1);
      n++;
    end
    chk("col rise", 16'(n <= 514), 16'h1);
    @(posedge clk);
    tx_en <= 1'h0;
    n = 0;
    while (col && n < 20) begin
      tick(1);
      n++;
    end
    chk("col fall", 16'(n <= 6), 16'h1);
    wr_reg(5'h00, 16'h2000);
  endtask

  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      stop_test();
    end
  end

  initial begin
    {rst_n, addr, wdata, wr, rd, an_res, stall} = '0;
    {tx_en, txd, line_rxd, line_dv, line_col} = '0;
    strap = 3'h6;
    pd_n = 1'h1;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'h1;
    tick(6);
    t_regs();
    $display("test registers done");
    t_restart();
    $display("test restart done");
    t_power();
    $display("test power down done");
    t_isolate();
    $display("test isolate done");
    t_loop();
    $display("test loopback done");
    t_col();
    $display("test collision done");
    stop_test();
  end
endmodule
